// ### giv_top.sv
`default_nettype none
`include "giv_defines.svh"
module giv_top #(
   parameter logic [31:0] LOGICAL_ID_RESET = 32'h0000_0000
) (
   input  wire logic                       clk,
   input  wire logic                       resetn,
   input  wire logic                       hsel,
   input  wire logic [31:0]                haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic [31:0]                hwdata,
   input  wire logic                       hready,
   output logic                            hreadyout,
   output logic                            hresp,
   output logic [31:0]                     hrdata,
   input  wire logic                       guestState,
   input  wire logic                       excValid,
   input  wire giv_pkg::giv_class_type     excClass,
   input  wire logic [31:0]                curPc,
   input  wire logic [31:0]                curMsr,
   input  wire logic [31:0]                excDear,
   input  wire logic [31:0]                excSyndrome,
   input  wire logic                       intLine,
   input  wire logic [31:0]                ackVector,
   input  wire logic                       guardedBusy,
   output logic                            takeValid,
   output logic                            takeGuest,
   output logic                            takeExt,
   output logic                            trapToHv,
   output logic                            extHeld,
   output logic                            irq,
   output logic [`GIV_PARTID_W-1:0]        partitionIdentity,
   output logic [`GIV_PROCID_W-1:0]        processIdentity
);
   import giv_pkg::*;

   giv_state_type          st;
   giv_state_type          next_st;
   logic                   coreGuest;
   logic                   extGuest;
   logic                   accept;
   logic                   intRise;
   logic                   extReady;
   logic [`GIV_EV_W-1:0]   ev;
   logic [`GIV_EV_W-1:0]   kept;

   giv_route u_route (
      .excClass   (excClass),
      .ctrl       (st.ctrl),
      .guestState (guestState),
      .coreGuest  (coreGuest),
      .extGuest   (extGuest)
   );

   // next-state logic: bus slave, exception entry, events
   always_comb begin
      next_st           = st;
      next_st.takeValid = 1'b0;
      next_st.takeExt   = 1'b0;
      next_st.trap      = 1'b0;
      ev                = '0;
      kept              = st.status;
      // address phase: reads get one wait state
      accept            = hsel & htrans[1] & hready;
      next_st.wrPend    = accept & hwrite;
      next_st.rdPend    = accept & ~hwrite;
      next_st.hreadyout = ~(accept & ~hwrite);
      if (accept) begin
         next_st.addr = haddr[7:0];
      end
      // write data phase, save registers banked by current level
      if (st.wrPend) begin
         case (st.addr)
            `GIV_OFF_CTRL: begin
               if (!guestState) begin
                  next_st.ctrl = hwdata[`GIV_CTRL_W-1:0];
               end
            end
            `GIV_OFF_RETADDR:   next_st.retAddr[guestState] = hwdata;
            `GIV_OFF_MACHSTATE: next_st.machState[guestState] = hwdata;
            `GIV_OFF_FAULTADDR: next_st.faultAddr[guestState] = hwdata;
            `GIV_OFF_SYNDROME:  next_st.syndrome[guestState] = hwdata;
            `GIV_OFF_VECPREFIX: begin
               if (guestState) begin
                  next_st.trap = 1'b1;
               end else begin
                  next_st.vecPrefix = hwdata;
               end
            end
            `GIV_OFF_VECOFFSET: begin
               if (guestState) begin
                  next_st.trap = 1'b1;
               end else begin
                  next_st.vecOffset = hwdata;
               end
            end
            `GIV_OFF_LOGICALID: begin
               if (!guestState) begin
                  next_st.logicalId = hwdata;
               end
            end
            `GIV_OFF_GUESTID:   next_st.guestId = hwdata;
            `GIV_OFF_PARTID: begin
               if (!guestState) begin
                  next_st.partId = hwdata[`GIV_PARTID_W-1:0];
               end
            end
            `GIV_OFF_PROCID: begin
               next_st.procId = hwdata[`GIV_PROCID_W-1:0];
            end
            `GIV_OFF_MASK:      next_st.mask = hwdata[`GIV_EV_W-1:0];
            default: ;
         endcase
      end
      // read wait cycle: sample after any write just completed
      if (st.rdPend) begin
         case (st.addr)
            `GIV_OFF_CTRL:      next_st.hrdata = 32'(st.ctrl);
            `GIV_OFF_RETADDR:   next_st.hrdata = st.retAddr[guestState];
            `GIV_OFF_MACHSTATE: next_st.hrdata = st.machState[guestState];
            `GIV_OFF_FAULTADDR: next_st.hrdata = st.faultAddr[guestState];
            `GIV_OFF_PROXYVEC:  next_st.hrdata = st.proxyVec[guestState];
            `GIV_OFF_SYNDROME:  next_st.hrdata = st.syndrome[guestState];
            `GIV_OFF_VECPREFIX: next_st.hrdata = st.vecPrefix;
            `GIV_OFF_VECOFFSET: next_st.hrdata = st.vecOffset;
            `GIV_OFF_LOGICALID: begin
               next_st.hrdata = guestState ? st.guestId : st.logicalId;
            end
            `GIV_OFF_GUESTID:   next_st.hrdata = st.guestId;
            `GIV_OFF_PARTID:    next_st.hrdata = 32'(st.partId);
            `GIV_OFF_PROCID:    next_st.hrdata = 32'(st.procId);
            `GIV_OFF_STATUS: begin
               next_st.hrdata = 32'(st.status);
               kept           = '0;
            end
            `GIV_OFF_MASK:      next_st.hrdata = 32'(st.mask);
            default:            next_st.hrdata = 32'h0000_0000;
         endcase
      end
      // pending-to-in-service edge from the controller
      intRise          = intLine & ~st.intLineQ;
      next_st.intLineQ = intLine;
      if (!intLine) begin
         next_st.extTaken = 1'b0;
      end
      if (intRise && st.ctrl[`GIV_CTRL_PROXY]) begin
         next_st.proxyVec[extGuest] = ackVector;
         ev[`GIV_EV_PROXY]          = 1'b1;
      end
      // guest-routed interrupt waits for guest state
      extReady = intLine & ~st.extTaken & ~guardedBusy &
                 (~extGuest | guestState);
      next_st.extHeld = intLine & ~st.extTaken & extGuest & ~guestState;
      // entry: core exception first, external the next free cycle
      if (excValid) begin
         next_st.takeValid = 1'b1;
         next_st.takeGuest = coreGuest;
         if (giv_is_normal(excClass)) begin
            next_st.retAddr[coreGuest]   = curPc;
            next_st.machState[coreGuest] = curMsr;
            next_st.faultAddr[coreGuest] = excDear;
            next_st.syndrome[coreGuest]  = excSyndrome;
         end
      end else if (extReady) begin
         next_st.takeValid           = 1'b1;
         next_st.takeExt             = 1'b1;
         next_st.takeGuest           = extGuest;
         next_st.extTaken            = 1'b1;
         next_st.retAddr[extGuest]   = curPc;
         next_st.machState[extGuest] = curMsr;
      end
      ev[`GIV_EV_HV]    = next_st.takeValid & ~next_st.takeGuest;
      ev[`GIV_EV_GUEST] = next_st.takeValid & next_st.takeGuest;
      ev[`GIV_EV_TRAP]  = next_st.trap;
      // sticky status: a new event beats the read-clear
      next_st.status = kept | ev;
      next_st.irq    = |(next_st.status & next_st.mask);
   end

   // state register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st           <= '0;
         st.ctrl      <= `GIV_CTRL_RST;
         st.mask      <= `GIV_MASK_RST;
         st.logicalId <= LOGICAL_ID_RESET;
         st.hreadyout <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register, except hresp which is tied low
   assign hreadyout         = st.hreadyout;
   assign hresp             = 1'b0;
   assign hrdata            = st.hrdata;
   assign takeValid         = st.takeValid;
   assign takeGuest         = st.takeGuest;
   assign takeExt           = st.takeExt;
   assign trapToHv          = st.trap;
   assign extHeld           = st.extHeld;
   assign irq               = st.irq;
   assign partitionIdentity = st.partId;
   assign processIdentity   = st.procId;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_sensitive_hv;
      excValid && !giv_is_normal(excClass) |=> takeValid && !takeGuest;
   endproperty
   a_sensitive_hv: assert property (p_sensitive_hv)
      else $error("sensitive exception taken at guest level");

   property p_ctrl_guest;
      excValid && excClass == CLS_DATA_TRANSLATION_MISS && guestState &&
      st.ctrl[`GIV_CTRL_DATA_TRANSLATION_MISS] |=> takeValid && takeGuest;
   endproperty
   a_ctrl_guest: assert property (p_ctrl_guest)
      else $error("enabled guest exception not taken at guest");

   property p_hv_level;
      excValid && !guestState |=> takeValid && !takeGuest;
   endproperty
   a_hv_level: assert property (p_hv_level)
      else $error("hypervisor code exception went to guest");

   property p_bank_save;
      excValid && giv_is_normal(excClass) |=>
         st.retAddr[takeGuest] == $past(curPc) &&
         st.syndrome[takeGuest] == $past(excSyndrome);
   endproperty
   a_bank_save: assert property (p_bank_save)
      else $error("context not saved into taken bank");

   property p_vec_trap;
      st.wrPend && guestState &&
      (st.addr == `GIV_OFF_VECPREFIX || st.addr == `GIV_OFF_VECOFFSET)
      |=> trapToHv && $stable(st.vecPrefix) && $stable(st.vecOffset);
   endproperty
   a_vec_trap: assert property (p_vec_trap)
      else $error("guest vector write not trapped");

   property p_ext_hold;
      intLine && extGuest && !guestState && !excValid |=> !takeExt;
   endproperty
   a_ext_hold: assert property (p_ext_hold)
      else $error("guest interrupt entered in hypervisor mode");

   property p_proxy;
      $rose(intLine) && st.ctrl[`GIV_CTRL_PROXY] |=>
         st.proxyVec[$past(extGuest)] == $past(ackVector) ##1
         $stable(st.proxyVec) [*2];
   endproperty
   a_proxy: assert property (p_proxy)
      else $error("proxy vector not captured or not held");

   property p_latency;
      $rose(intLine) && !extGuest && !guardedBusy && !excValid
      |-> ##[1:10] takeExt;
   endproperty
   a_latency: assert property (p_latency)
      else $error("interrupt entry exceeded bound");

   property p_part_guard;
      st.wrPend && guestState && st.addr == `GIV_OFF_PARTID
      |=> $stable(st.partId);
   endproperty
   a_part_guard: assert property (p_part_guard)
      else $error("guest changed partition identity");

   property p_guest_id_read;
      st.rdPend && guestState && st.addr == `GIV_OFF_LOGICALID
      |=> hrdata == $past(st.guestId) && hreadyout;
   endproperty
   a_guest_id_read: assert property (p_guest_id_read)
      else $error("guest read returned logical identity");

   property p_c_guest_take;
      takeValid && takeGuest;
   endproperty
   c_guest_take: cover property (p_c_guest_take);

   property p_c_held_then_taken;
      extHeld ##[1:20] takeExt && takeGuest;
   endproperty
   c_held_then_taken: cover property (p_c_held_then_taken);

   property p_c_trap;
      trapToHv ##1 irq;
   endproperty
   c_trap: cover property (p_c_trap);
endmodule // giv_top
`default_nettype wire

// ### giv_defines.svh
`ifndef GIV_DEFINES_SVH
`define GIV_DEFINES_SVH
// register byte offsets on the bus
`define GIV_OFF_CTRL      8'h00
`define GIV_OFF_RETADDR   8'h04
`define GIV_OFF_MACHSTATE 8'h08
`define GIV_OFF_FAULTADDR 8'h0c
`define GIV_OFF_PROXYVEC  8'h10
`define GIV_OFF_SYNDROME  8'h14
`define GIV_OFF_VECPREFIX 8'h18
`define GIV_OFF_VECOFFSET 8'h1c
`define GIV_OFF_LOGICALID 8'h20
`define GIV_OFF_GUESTID   8'h24
`define GIV_OFF_PARTID    8'h28
`define GIV_OFF_PROCID    8'h2c
`define GIV_OFF_STATUS    8'h30
`define GIV_OFF_MASK      8'h34
// control register bit positions
`define GIV_CTRL_EXT   0
`define GIV_CTRL_DSI   1
`define GIV_CTRL_ISI   2
`define GIV_CTRL_INSTR_TRANSLATION_MISS  3
`define GIV_CTRL_DATA_TRANSLATION_MISS  4
`define GIV_CTRL_PROXY 5
`define GIV_CTRL_W     6
// status / mask bit positions
`define GIV_EV_HV    0
`define GIV_EV_GUEST 1
`define GIV_EV_TRAP  2
`define GIV_EV_PROXY 3
`define GIV_EV_W     4
// widths and reset values
`define GIV_PARTID_W  6
`define GIV_PROCID_W  8
`define GIV_CTRL_RST  6'h00
`define GIV_MASK_RST  4'h0
// interrupt entry bound in cycles
`define GIV_ENTRY_MAX 10
`endif

// ### giv_pkg.sv
`default_nettype none
`include "giv_defines.svh"
package giv_pkg;
   // exception classes raised by the core pipeline
   typedef enum logic [2:0] {
      CLS_DSI, CLS_ISI, CLS_INSTR_TRANSLATION_MISS, CLS_DATA_TRANSLATION_MISS, CLS_OTHER,
      CLS_CRIT, CLS_DEBUG, CLS_MCHK
   } giv_class_type;

   // whole state of the top module; bank index 0 hypervisor, 1 guest
   typedef struct packed {
      logic [`GIV_CTRL_W-1:0]   ctrl;
      logic [1:0][31:0]         retAddr;
      logic [1:0][31:0]         machState;
      logic [1:0][31:0]         faultAddr;
      logic [1:0][31:0]         proxyVec;
      logic [1:0][31:0]         syndrome;
      logic [31:0]              vecPrefix;
      logic [31:0]              vecOffset;
      logic [31:0]              logicalId;
      logic [31:0]              guestId;
      logic [`GIV_PARTID_W-1:0] partId;
      logic [`GIV_PROCID_W-1:0] procId;
      logic [`GIV_EV_W-1:0]     status;
      logic [`GIV_EV_W-1:0]     mask;
      logic                     irq;
      logic                     takeValid;
      logic                     takeGuest;
      logic                     takeExt;
      logic                     extHeld;
      logic                     extTaken;
      logic                     intLineQ;
      logic                     trap;
      logic                     wrPend;
      logic                     rdPend;
      logic                     hreadyout;
      logic [7:0]               addr;
      logic [31:0]              hrdata;
   } giv_state_type;

   // normal-level classes use the duplicated save banks
   function automatic logic giv_is_normal(giv_class_type c);
      return (c == CLS_DSI) || (c == CLS_ISI) || (c == CLS_INSTR_TRANSLATION_MISS) ||
             (c == CLS_DATA_TRANSLATION_MISS) || (c == CLS_OTHER);
   endfunction
endpackage
`default_nettype wire

// ### giv_route.sv
`default_nettype none
`include "giv_defines.svh"
module giv_route (
   input  wire giv_pkg::giv_class_type    excClass,
   input  wire logic [`GIV_CTRL_W-1:0]    ctrl,
   input  wire logic                      guestState,
   output logic                           coreGuest,
   output logic                           extGuest
);
   import giv_pkg::*;

   // level decision for core-initiated exceptions
   always_comb begin
      case (excClass)
         CLS_CRIT, CLS_DEBUG, CLS_MCHK: coreGuest = 1'b0;
         CLS_DSI:   coreGuest = guestState & ctrl[`GIV_CTRL_DSI];
         CLS_ISI:   coreGuest = guestState & ctrl[`GIV_CTRL_ISI];
         CLS_INSTR_TRANSLATION_MISS:  coreGuest = guestState & ctrl[`GIV_CTRL_INSTR_TRANSLATION_MISS];
         CLS_DATA_TRANSLATION_MISS:  coreGuest = guestState & ctrl[`GIV_CTRL_DATA_TRANSLATION_MISS];
         CLS_OTHER: coreGuest = guestState;
         default:   coreGuest = 1'b0;
      endcase
   end

   // normal external interrupts follow the control bit
   assign extGuest = ctrl[`GIV_CTRL_EXT];
endmodule // giv_route
`default_nettype wire

// ### giv_pic_model.sv
`default_nettype none
// one core's view of the soc interrupt controller
module giv_pic_model #(
   parameter int CORE_NUM = 0 // fixed physical core number
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        deliver,
   input  wire logic [7:0]  targets,
   input  wire logic [31:0] vector,
   input  wire logic [3:0]  latency,
   input  wire logic        end_of_interrupt_reg,
   output logic             intLine,
   output logic [31:0]      ackVector
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] ackBank [8];
   logic [3:0]  waitCnt;
   logic        pending;

   // banked acknowledge, delayed move to in-service, release on eoi
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pending <= 1'b0;
         waitCnt <= 4'h0;
         intLine <= 1'b0;
         ackVector <= 32'h0;
      end else begin
         if (deliver) begin
            for (int c = 0; c < 8; c++) begin
               if (targets[c]) ackBank[c] <= vector;
            end
            pending <= targets[CORE_NUM];
            waitCnt <= latency;
         end else if (pending && waitCnt != 4'h0) begin
            waitCnt <= waitCnt - 4'h1;
         end else if (pending) begin
            pending <= 1'b0;
            intLine <= 1'b1;
            ackVector <= ackBank[CORE_NUM];
         end
         // released line shows the inverse of the last value
         if (end_of_interrupt_reg) begin
            intLine <= 1'b0;
            ackVector <= ~ackVector;
         end
      end
   end
endmodule // giv_pic_model
`default_nettype wire

// ### guest_interrupt_virtualization_tb.sv
`default_nettype none
module guest_interrupt_virtualization_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import giv_pkg::*;
   localparam logic [31:0] ID_RST = 32'h0000_0005;
   logic          clk, resetn, hsel, hwrite, gs, excValid, busy;
   logic          deliver, end_of_interrupt_reg, hreadyout, hresp, intLine, irq;
   logic          takeValid, takeGuest, takeExt, trapToHv, extHeld;
   logic [1:0]    htrans;
   logic [3:0]    lat;
   logic [5:0]    partId, ct;
   logic [7:0]    procId, tgt;
   logic [31:0]   haddr, hwdata, hrdata, pc, rd, vec, ackVector;
   giv_class_type cls;
   int            fails, check_count, extCnt, trapCnt, n;

   giv_top #(.LOGICAL_ID_RESET(ID_RST)) dut_u (
      .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .guestState(gs), .excValid(excValid),
      .excClass(cls), .curPc(pc), .curMsr(~pc), .excDear(pc + 32'h1),
      .excSyndrome(pc ^ 32'hffff), .intLine(intLine),
      .ackVector(ackVector), .guardedBusy(busy), .takeValid(takeValid),
      .takeGuest(takeGuest), .takeExt(takeExt), .trapToHv(trapToHv),
      .extHeld(extHeld), .irq(irq), .partitionIdentity(partId),
      .processIdentity(procId));

   giv_pic_model #(.CORE_NUM(0)) pic_u (
      .clk(clk), .resetn(resetn), .deliver(deliver), .targets(tgt),
      .vector(vec), .latency(lat), .end_of_interrupt_reg(end_of_interrupt_reg), .intLine(intLine),
      .ackVector(ackVector));

   // clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // count external interrupt entry pulses and trap pulses
   always @(posedge clk) begin
      if (takeValid === 1'b1 && takeExt === 1'b1) extCnt++;
      if (trapToHv === 1'b1) trapCnt++;
   end

   task automatic chk(input string s, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", s, e, g);
      end
   endtask

   task automatic chk_bit(input string s, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s expected %b seen %b", s, e, g);
      end
   endtask

   // one ahb single transfer at level g
   task automatic bus(input logic g, input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      gs <= g;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask

   task automatic rdchk(input logic g, input logic [7:0] a,
                        input logic [31:0] e, input string s);
      bus(g, 1'b0, a, 32'h0);
      chk(s, e, rd);
   endtask

   task automatic raise(input giv_class_type c, input logic g,
                        input logic [31:0] p);
      @(posedge clk);
      excValid <= 1'b1;
      cls <= c;
      gs <= g;
      pc <= p;
      @(posedge clk);
      excValid <= 1'b0;
      #1;
   endtask

   task automatic fire(input logic [7:0] t, input logic [31:0] v,
                       input logic [3:0] l);
      @(posedge clk);
      deliver <= 1'b1;
      tgt <= t;
      vec <= v;
      lat <= l;
      @(posedge clk);
      deliver <= 1'b0;
   endtask

   task automatic idle(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   // level an exception class should be taken at
   function automatic logic exp_guest(giv_class_type c, logic g,
                                      logic [5:0] m);
      if (c > CLS_OTHER) return 1'b0;
      if (c == CLS_OTHER) return g;
      return g & m[int'(c) + 1];
   endfunction

   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // watchdog
   initial begin
      idle(20000);
      fails++;
      stop_test;
   end

   // main sequence
   initial begin
      {resetn, hsel, hwrite, gs, excValid, busy, deliver, end_of_interrupt_reg} = '0;
      {haddr, hwdata, pc, vec, htrans, lat, tgt} = '0;
      cls = CLS_DSI;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chk_bit("irq", 1'b0, irq);
      rdchk(0, 8'h20, ID_RST, "logical id");
      chk_bit("hresp", 1'b0, hresp);
      rdchk(0, 8'h34, 32'h0, "mask");
      bus(0, 1, 8'h20, 32'h77);
      rdchk(0, 8'h20, 32'h77, "logical id");
      bus(1, 1, 8'h24, 32'h9);
      rdchk(1, 8'h20, 32'h9, "guest id");
      bus(0, 1, 8'h28, '1);
      bus(1, 1, 8'h28, '0);
      rdchk(0, 8'h28, 32'h3f, "partition");
      chk("partition port", 32'h3f, {26'h0, partId});
      bus(1, 1, 8'h2c, '1);
      rdchk(1, 8'h2c, 32'hff, "process");
      chk("process port", 32'hff, {24'h0, procId});
      rdchk(0, 8'h3c, 32'h0, "unmapped");
      $display("test identities done");
      for (int k = 0; k < 2; k++) begin
         ct = k ? 6'h1e : 6'h00;
         bus(0, 1, 8'h00, {26'h0, ct});
         for (int g = 0; g < 2; g++) begin
            for (int c = 0; c < 8; c++) begin
               raise(giv_class_type'(c), g[0], 32'h100 + c);
               chk_bit("take", 1'b1, takeValid);
               chk_bit("level", exp_guest(giv_class_type'(c), g[0], ct),
                       takeGuest);
            end
         end
      end
      chk_bit("irq masked", 1'b0, irq);
      bus(0, 1, 8'h34, 32'h3);
      idle(2);
      chk_bit("irq", 1'b1, irq);
      rdchk(0, 8'h30, 32'h3, "status");
      idle(2);
      chk_bit("irq cleared", 1'b0, irq);
      $display("test routing done");
      bus(0, 1, 8'h00, 32'h02);
      raise(CLS_DSI, 1, 32'h1000);
      raise(CLS_DSI, 0, 32'h2000);
      rdchk(1, 8'h04, 32'h1000, "guest ret");
      rdchk(1, 8'h08, ~32'h1000, "guest state");
      rdchk(1, 8'h0c, 32'h1001, "guest fault");
      rdchk(1, 8'h14, 32'h1000 ^ 32'hffff, "guest syn");
      rdchk(0, 8'h04, 32'h2000, "hv ret");
      rdchk(0, 8'h14, 32'h2000 ^ 32'hffff, "hv syn");
      $display("test banks done");
      for (int i = 0; i < 2; i++) begin
         bus(1, 1, 8'h18 + 8'(4 * i), 32'hdead0000);
         idle(3);
         chk("traps", 32'(i + 1), 32'(trapCnt));
         rdchk(0, 8'h18 + 8'(4 * i), 32'h0, "vector reg");
      end
      bus(0, 1, 8'h18, 32'h1234);
      rdchk(0, 8'h18, 32'h1234, "vector prefix");
      rdchk(0, 8'h30, 32'h7, "status trap");
      $display("test trap done");
      bus(0, 1, 8'h00, 32'h21);
      n = extCnt;
      fire(8'h01, 32'ha5, 4'h0);
      idle(12);
      chk_bit("held", 1'b1, extHeld);
      chk("entries", 32'(n), 32'(extCnt));
      gs <= 1'b1;
      idle(11);
      chk("entries", 32'(n + 1), 32'(extCnt));
      chk_bit("ext level", 1'b1, takeGuest);
      chk_bit("held", 1'b0, extHeld);
      rdchk(1, 8'h10, 32'ha5, "proxy");
      end_of_interrupt_reg <= 1'b1;
      idle(1);
      end_of_interrupt_reg <= 1'b0;
      idle(2);
      rdchk(1, 8'h10, 32'ha5, "proxy kept");
      busy <= 1'b1;
      fire(8'h03, 32'h5a, 4'h3);
      idle(12);
      chk("entries", 32'(n + 1), 32'(extCnt));
      rdchk(1, 8'h10, 32'h5a, "proxy new");
      busy <= 1'b0;
      idle(11);
      chk("entries", 32'(n + 2), 32'(extCnt));
      // hypervisor-routed interrupt, entered without delay
      end_of_interrupt_reg <= 1'b1;
      idle(1);
      end_of_interrupt_reg <= 1'b0;
      bus(0, 1, 8'h00, 32'h20);
      fire(8'h01, 32'h3c, 4'h0);
      idle(10);
      chk("entries", 32'(n + 3), 32'(extCnt));
      chk_bit("ext level", 1'b0, takeGuest);
      rdchk(0, 8'h10, 32'h3c, "proxy hv");
      $display("test external done");
      stop_test;
   end
endmodule // guest_interrupt_virtualization_tb
`default_nettype wire
